// ### logic/iclr_acc_if.sv
// decoded register access passed from the bus port to the register bank
`timescale 1ns/10ps
interface iclr_acc_if;
    logic wr;
    logic rd;
    logic hit;
    logic word_hi;
    logic [iclr_pkg::SEL_W-1:0] sel;
    logic [iclr_pkg::DATA_W-1:0] wdata;
    modport port (output wr, rd, hit, word_hi, sel, wdata);
    modport core (input wr, rd, hit, word_hi, sel, wdata);
endinterface

// ### logic/iclr_bus_port.sv
// word access decoder: selects register, pairs wide register words
`timescale 1ns/10ps
module iclr_bus_port (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // word access
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [iclr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [iclr_pkg::WORD_W-1:0] i_wdata,
    // decoded access
    iclr_acc_if.port acc
);
    import iclr_pkg::*;

    typedef struct packed {
        logic [WORD_W-1:0] hi_word;
    } iclr_port_state_t;

    iclr_port_state_t st;
    iclr_port_state_t next_st;

    // decode; upper word writes are held until the lower word arrives
    always_comb begin
        acc.hit = (i_addr >= ADDR_PUMP_STATE_HIGH) && (i_addr <= ADDR_LAST);
        acc.sel = sel_of(i_addr);
        if (i_addr < ADDR_WIDE_BASE) begin
            acc.word_hi = 1'b0;
            acc.wdata = {{WORD_W{1'b0}}, i_wdata};
        end else begin
            acc.word_hi = (i_addr[0] == ADDR_WIDE_BASE[0]);
            acc.wdata = {st.hi_word, i_wdata};
        end
        acc.wr = i_wr && acc.hit && !acc.word_hi;
        acc.rd = i_rd && acc.hit;
        next_st = st;
        if (i_wr && acc.hit && acc.word_hi) begin
            next_st.hi_word = i_wdata;
        end
        if (i_rst) begin
            next_st = '0;
        end
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        st <= next_st;
    end
endmodule

// ### logic/iclr_pkg.sv
// register map, codes and limits of the injection controller register bank
package iclr_pkg;
    localparam int ADDR_W = 20;
    localparam int WORD_W = 16;
    localparam int DATA_W = 32;
    localparam int SEL_W = 5;
    localparam int TOTAL_W = 15;

    // modbus word addresses; wide registers hold upper word first
    localparam logic [19:0] ADDR_PUMP_STATE_HIGH = 20'h6_1f02;
    localparam logic [19:0] ADDR_PUMP_STATE_LOW = 20'h6_1f03;
    localparam logic [19:0] ADDR_GRAND_TOTAL_SHORT = 20'h6_1f04;
    localparam logic [19:0] ADDR_DESIRED_FLOW_RATE = 20'h6_1f05;
    localparam logic [19:0] ADDR_PUMP_INHIBIT = 20'h6_1f06;
    localparam logic [19:0] ADDR_ALARM_CLEAR = 20'h6_1f07;
    localparam logic [19:0] ADDR_HEARTBEAT_TICK = 20'h6_1f08;
    localparam logic [19:0] ADDR_COMMS_WATCH_ENABLE = 20'h6_1f09;
    localparam logic [19:0] ADDR_TANK_NOTIFY_LEVEL = 20'h6_1f0a;
    localparam logic [19:0] ADDR_TANK_SHUTOFF_LEVEL = 20'h6_1f0b;
    localparam logic [19:0] ADDR_ANALOG_OUT_ON_VIEW = 20'h6_1f0c;
    localparam logic [19:0] ADDR_ANALOG_OUT_MIN_VIEW = 20'h6_1f0e;
    localparam logic [19:0] ADDR_ANALOG_OUT_MAX_VIEW = 20'h6_1f10;
    localparam logic [19:0] ADDR_ANALOG_OUT_KIND = 20'h6_1f12;
    localparam logic [19:0] ADDR_ANALOG_OUT_ON = 20'h6_1f14;
    localparam logic [19:0] ADDR_ANALOG_OUT_MIN = 20'h6_1f16;
    localparam logic [19:0] ADDR_ANALOG_OUT_MAX = 20'h6_1f18;
    localparam logic [19:0] ADDR_TEMPERATURE_READING = 20'h6_1f1a;
    localparam logic [19:0] ADDR_TEMP_MODE_VIEW = 20'h6_1f1c;
    localparam logic [19:0] ADDR_TEMP_SETPOINT_VIEW = 20'h6_1f1e;
    localparam logic [19:0] ADDR_TEMP_MODE = 20'h6_1f20;
    localparam logic [19:0] ADDR_TEMP_SETPOINT = 20'h6_1f22;
    localparam logic [19:0] ADDR_LAST = ADDR_TEMP_SETPOINT + 20'h0_0001;
    localparam logic [19:0] ADDR_WIDE_BASE = ADDR_ANALOG_OUT_ON_VIEW;
    localparam logic [4:0] NUM_SHORT =
        5'(ADDR_WIDE_BASE - ADDR_PUMP_STATE_HIGH);

    // register select: one code per word below ADDR_WIDE_BASE (both pump state words too), one for both words of a wide one
    function automatic logic [SEL_W-1:0] sel_of(input logic [19:0] a);
        logic [19:0] d;
        if (a < ADDR_WIDE_BASE) begin
            d = a - ADDR_PUMP_STATE_HIGH;
            return d[SEL_W-1:0];
        end
        d = a - ADDR_WIDE_BASE;
        return NUM_SHORT + d[SEL_W:1];
    endfunction

    localparam logic [4:0] SEL_PUMP_STATE_LOW = sel_of(ADDR_PUMP_STATE_LOW);
    localparam logic [4:0] SEL_TOTAL = sel_of(ADDR_GRAND_TOTAL_SHORT);
    localparam logic [4:0] SEL_FLOW = sel_of(ADDR_DESIRED_FLOW_RATE);
    localparam logic [4:0] SEL_INHIBIT = sel_of(ADDR_PUMP_INHIBIT);
    localparam logic [4:0] SEL_CLEAR = sel_of(ADDR_ALARM_CLEAR);
    localparam logic [4:0] SEL_HB = sel_of(ADDR_HEARTBEAT_TICK);
    localparam logic [4:0] SEL_WATCH = sel_of(ADDR_COMMS_WATCH_ENABLE);
    localparam logic [4:0] SEL_NOTIFY = sel_of(ADDR_TANK_NOTIFY_LEVEL);
    localparam logic [4:0] SEL_SHUTOFF = sel_of(ADDR_TANK_SHUTOFF_LEVEL);
    localparam logic [4:0] SEL_AON_V = sel_of(ADDR_ANALOG_OUT_ON_VIEW);
    localparam logic [4:0] SEL_AMIN_V = sel_of(ADDR_ANALOG_OUT_MIN_VIEW);
    localparam logic [4:0] SEL_AMAX_V = sel_of(ADDR_ANALOG_OUT_MAX_VIEW);
    localparam logic [4:0] SEL_AKIND = sel_of(ADDR_ANALOG_OUT_KIND);
    localparam logic [4:0] SEL_AON = sel_of(ADDR_ANALOG_OUT_ON);
    localparam logic [4:0] SEL_AMIN = sel_of(ADDR_ANALOG_OUT_MIN);
    localparam logic [4:0] SEL_AMAX = sel_of(ADDR_ANALOG_OUT_MAX);
    localparam logic [4:0] SEL_TEMP = sel_of(ADDR_TEMPERATURE_READING);
    localparam logic [4:0] SEL_TMODE_V = sel_of(ADDR_TEMP_MODE_VIEW);
    localparam logic [4:0] SEL_TSET_V = sel_of(ADDR_TEMP_SETPOINT_VIEW);
    localparam logic [4:0] SEL_TMODE = sel_of(ADDR_TEMP_MODE);
    localparam logic [4:0] SEL_TSET = sel_of(ADDR_TEMP_SETPOINT);

    // field positions, limits and reset values
    localparam int CTRL_BIT = 0;
    localparam logic [14:0] TOTAL_MAX = 15'h7fff;
    localparam logic signed [31:0] TANK_MIN = 32'sh0000_0000;
    localparam logic signed [31:0] TANK_MAX = 32'sh0000_3840;
    localparam logic signed [31:0] TEMP_MIN = 32'shffff_ffd8;
    localparam logic signed [31:0] TEMP_MAX = 32'sh0000_0076;
    localparam logic [31:0] TEMP_MODE_MAX = 32'h0000_0003;
    localparam logic INHIBIT_RST = 1'b1;

    typedef enum logic [2:0] {
        PS_STANDBY = 3'b000,
        PS_RUN = 3'b001,
        PS_LOCK_ALARM = 3'b010,
        PS_LOCK_REMOTE = 3'b011,
        PS_LOCK_POWER = 3'b100,
        PS_LOCK_TEMP = 3'b101
    } iclr_pump_code_t;

    typedef enum logic [1:0] {
        TM_DISABLED = 2'b00,
        TM_DISPLAY = 2'b01,
        TM_ON_BELOW = 2'b10,
        TM_ON_ABOVE = 2'b11
    } iclr_temp_mode_t;
endpackage

// ### logic/iclr_regs.sv
// register bank of the chemical injection controller, word addressed
`timescale 1ns/10ps
module iclr_regs (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register access
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [iclr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [iclr_pkg::WORD_W-1:0] i_wdata,
    output logic [iclr_pkg::WORD_W-1:0] o_rdata,
    output logic o_rd_valid,
    output logic o_rd_err,
    // pump
    input wire iclr_pkg::iclr_pump_code_t i_lockout_code,
    output logic o_pump_run_cmd,
    // totaliser and flow
    input wire logic i_flow_mode,
    input wire logic i_volume_tick,
    output logic [iclr_pkg::WORD_W-1:0] o_flow_rate_target,
    // alarms and comms watch
    output logic o_alarm_clear,
    output logic o_heartbeat_tick,
    output logic [iclr_pkg::WORD_W-1:0] o_heartbeat_count,
    output logic o_comms_watch_on,
    // tank level
    input wire logic i_tank_level_monitor_option,
    input wire logic [iclr_pkg::WORD_W-1:0] i_tank_height,
    output logic o_tank_notify,
    output logic o_tank_shutoff,
    // analog output
    input wire logic [iclr_pkg::DATA_W-1:0] i_aout_kind,
    output logic o_aout_enable,
    output logic [iclr_pkg::DATA_W-1:0] o_aout_min,
    output logic [iclr_pkg::DATA_W-1:0] o_aout_max,
    // temperature
    input wire logic signed [iclr_pkg::DATA_W-1:0] i_temperature,
    output iclr_pkg::iclr_temp_mode_t o_temp_mode,
    output logic signed [iclr_pkg::DATA_W-1:0] o_temp_setpoint,
    output logic o_temp_demand
);
    import iclr_pkg::*;

    typedef struct packed {
        logic [1:0] tlm_sync;
        logic inhibit;
        logic [TOTAL_W-1:0] total;
        logic [WORD_W-1:0] flow_rate;
        logic [WORD_W-1:0] heartbeat;
        logic watch_on;
        logic [WORD_W-1:0] notify_lvl;
        logic [WORD_W-1:0] shutoff_lvl;
        logic aout_on;
        logic [DATA_W-1:0] aout_min;
        logic [DATA_W-1:0] aout_max;
        iclr_temp_mode_t temp_mode;
        logic signed [DATA_W-1:0] setpoint;
        logic [WORD_W-1:0] rdata;
        logic rd_valid;
        logic rd_err;
        logic alarm_clear;
        logic hb_tick;
        logic tank_notify;
        logic tank_shutoff;
        logic [DATA_W-1:0] aout_min_out;
        logic [DATA_W-1:0] aout_max_out;
        logic temp_demand;
    } iclr_regs_state_t;

    iclr_acc_if acc ();
    iclr_regs_state_t st;
    iclr_regs_state_t next_st;
    logic signed [DATA_W-1:0] tank_in;
    logic signed [DATA_W-1:0] tank_clamped;
    logic set_ok;
    iclr_pump_code_t pump_code;
    logic [DATA_W-1:0] rd_word;

    // word decoder and upper word holding
    iclr_bus_port u_port (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .acc(acc.port)
    );

    // tank triggers are 16-bit words taken as signed for the clamp
    assign tank_in = {{WORD_W{acc.wdata[WORD_W-1]}}, acc.wdata[WORD_W-1:0]};

    // clamp of tank trigger writes
    iclr_value_guard #(
        .LO(TANK_MIN),
        .HI(TANK_MAX)
    ) u_tank_guard (
        .i_value(tank_in),
        .o_in_range(),
        .o_clamped(tank_clamped)
    );

    // acceptance window of setpoint writes
    iclr_value_guard #(
        .LO(TEMP_MIN),
        .HI(TEMP_MAX)
    ) u_temp_guard (
        .i_value(acc.wdata),
        .o_in_range(set_ok),
        .o_clamped()
    );

    // pump status code: lockouts first, else run unless inhibited
    always_comb begin
        if (i_lockout_code != PS_STANDBY) begin
            pump_code = i_lockout_code;
        end else if (st.inhibit) begin
            pump_code = PS_STANDBY;
        end else begin
            pump_code = PS_RUN;
        end
    end

    // read value of the selected register, views mirror live copies
    always_comb begin
        case (acc.sel)
            SEL_PUMP_STATE_LOW: rd_word = DATA_W'(pump_code);
            SEL_TOTAL: rd_word = DATA_W'(st.total);
            SEL_FLOW: rd_word = DATA_W'(st.flow_rate);
            SEL_INHIBIT: rd_word = DATA_W'(st.inhibit);
            SEL_HB: rd_word = DATA_W'(st.heartbeat);
            SEL_WATCH: rd_word = DATA_W'(st.watch_on);
            SEL_NOTIFY: rd_word = DATA_W'(st.notify_lvl);
            SEL_SHUTOFF: rd_word = DATA_W'(st.shutoff_lvl);
            SEL_AON_V, SEL_AON: rd_word = DATA_W'(st.aout_on);
            SEL_AMIN_V, SEL_AMIN: rd_word = st.aout_min;
            SEL_AMAX_V, SEL_AMAX: rd_word = st.aout_max;
            SEL_AKIND: rd_word = i_aout_kind;
            SEL_TEMP: rd_word = $unsigned(i_temperature);
            SEL_TMODE_V, SEL_TMODE: rd_word = DATA_W'(st.temp_mode);
            SEL_TSET_V, SEL_TSET: rd_word = $unsigned(st.setpoint);
            default: rd_word = '0; // upper pump word, write-only clear
        endcase
    end

    // next state of the whole bank
    always_comb begin
        next_st = st;
        next_st.alarm_clear = 1'b0;
        next_st.hb_tick = 1'b0;
        // option pin through two flops, only the second is read
        next_st.tlm_sync = {st.tlm_sync[0], i_tank_level_monitor_option};

        // totaliser counts volume only in flow mode, wraps at the top
        if (i_flow_mode && i_volume_tick) begin
            if (st.total == TOTAL_MAX) begin
                next_st.total = '0;
            end else begin
                next_st.total = st.total + 1'b1;
            end
        end

        // writes; read-only selects fall to the default and change nothing
        if (acc.wr) begin
            case (acc.sel)
                SEL_TOTAL: next_st.total = acc.wdata[TOTAL_W-1:0];
                SEL_FLOW: next_st.flow_rate = acc.wdata[WORD_W-1:0];
                SEL_INHIBIT: begin
                    next_st.inhibit = acc.wdata[CTRL_BIT];
                end
                SEL_CLEAR: next_st.alarm_clear = acc.wdata[CTRL_BIT];
                SEL_HB: begin
                    if (st.watch_on) begin
                        next_st.heartbeat = st.heartbeat + 1'b1;
                        next_st.hb_tick = 1'b1;
                    end
                end
                SEL_WATCH: next_st.watch_on = acc.wdata[CTRL_BIT];
                SEL_NOTIFY: begin
                    next_st.notify_lvl = tank_clamped[WORD_W-1:0];
                end
                SEL_SHUTOFF: begin
                    next_st.shutoff_lvl = tank_clamped[WORD_W-1:0];
                end
                SEL_AON: next_st.aout_on = acc.wdata[CTRL_BIT];
                SEL_AMIN: next_st.aout_min = acc.wdata;
                SEL_AMAX: next_st.aout_max = acc.wdata;
                SEL_TMODE: begin
                    if (acc.wdata <= TEMP_MODE_MAX) begin
                        next_st.temp_mode = iclr_temp_mode_t'(acc.wdata[1:0]);
                    end
                end
                SEL_TSET: begin
                    if (set_ok) begin
                        next_st.setpoint = acc.wdata;
                    end
                end
                default: ;
            endcase
        end

        // read answer: data held until the next read, valid and error for one cycle
        next_st.rd_valid = i_rd;
        if (i_rd) begin
            next_st.rd_err = !acc.hit;
            if (!acc.hit) begin
                next_st.rdata = '0;
            end else if (acc.word_hi) begin
                next_st.rdata = rd_word[DATA_W-1:WORD_W];
            end else begin
                next_st.rdata = rd_word[WORD_W-1:0];
            end
        end else begin
            next_st.rd_err = 1'b0;
        end

        // tank comparisons only with the monitor option fitted
        next_st.tank_notify = st.tlm_sync[1]
            && (i_tank_height <= st.notify_lvl);
        next_st.tank_shutoff = st.tlm_sync[1]
            && (i_tank_height <= st.shutoff_lvl);

        // analog limits pass only while the output is enabled
        next_st.aout_min_out = st.aout_on ? st.aout_min : '0;
        next_st.aout_max_out = st.aout_on ? st.aout_max : '0;

        // setpoint acts only in the two control modes
        case (st.temp_mode)
            TM_ON_BELOW: begin
                next_st.temp_demand = i_temperature < st.setpoint;
            end
            TM_ON_ABOVE: begin
                next_st.temp_demand = i_temperature > st.setpoint;
            end
            default: next_st.temp_demand = 1'b0;
        endcase

        if (i_rst) begin
            next_st = '0;
            next_st.inhibit = INHIBIT_RST;
        end
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        st <= next_st;
    end

    // outputs straight from the state
    assign o_rdata = st.rdata;
    assign o_rd_valid = st.rd_valid;
    assign o_rd_err = st.rd_err;
    assign o_pump_run_cmd = !st.inhibit;
    assign o_flow_rate_target = st.flow_rate;
    assign o_alarm_clear = st.alarm_clear;
    assign o_heartbeat_tick = st.hb_tick;
    assign o_heartbeat_count = st.heartbeat;
    assign o_comms_watch_on = st.watch_on;
    assign o_tank_notify = st.tank_notify;
    assign o_tank_shutoff = st.tank_shutoff;
    assign o_aout_enable = st.aout_on;
    assign o_aout_min = st.aout_min_out;
    assign o_aout_max = st.aout_max_out;
    assign o_temp_mode = st.temp_mode;
    assign o_temp_setpoint = st.setpoint;
    assign o_temp_demand = st.temp_demand;
endmodule

// ### logic/iclr_value_guard.sv
// range test and clamp of a signed written value
`timescale 1ns/10ps
module iclr_value_guard #(
    parameter logic signed [31:0] LO = iclr_pkg::TANK_MIN,
    parameter logic signed [31:0] HI = iclr_pkg::TANK_MAX
) (
    // value under test
    input wire logic signed [iclr_pkg::DATA_W-1:0] i_value,
    // verdicts
    output logic o_in_range,
    output logic signed [iclr_pkg::DATA_W-1:0] o_clamped
);
    import iclr_pkg::*;

    // inclusive window, saturate outside it
    always_comb begin
        o_in_range = (i_value >= LO) && (i_value <= HI);
        if (i_value < LO) begin
            o_clamped = LO;
        end else if (i_value > HI) begin
            o_clamped = HI;
        end else begin
            o_clamped = i_value;
        end
    end
endmodule

// ### sim/iclr_mbus_master.sv
// modbus master model issuing word reads and writes
`timescale 1ns/10ps
module iclr_mbus_master (
    // clock
    input wire logic i_ref_clk,
    // word access toward the register bank
    output logic o_wr,
    output logic o_rd,
    output logic [iclr_pkg::ADDR_W-1:0] o_addr,
    output logic [iclr_pkg::WORD_W-1:0] o_wdata
);
    import iclr_pkg::*;
    // idle bus at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = '0;
        o_wdata = '0;
    end
    // one word held for one sampling edge; released lines show junk
    task automatic access(input logic w, input logic [19:0] a,
            input logic [15:0] d);
        @(negedge i_ref_clk);
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = d;
        @(negedge i_ref_clk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule

// ### sim/iclr_regs_props.sv
// assertions on the ports of the injection controller register bank
`timescale 1ns/10ps
module iclr_regs_props (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register access
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [iclr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [iclr_pkg::WORD_W-1:0] i_wdata,
    input wire logic [iclr_pkg::WORD_W-1:0] o_rdata,
    input wire logic o_rd_valid,
    input wire logic o_rd_err,
    // controls and status
    input wire logic i_tank_level_monitor_option,
    input wire logic signed [iclr_pkg::DATA_W-1:0] i_temperature,
    input wire logic o_pump_run_cmd,
    input wire logic o_heartbeat_tick,
    input wire logic [iclr_pkg::WORD_W-1:0] o_heartbeat_count,
    input wire logic o_comms_watch_on,
    input wire logic o_tank_notify,
    input wire logic o_tank_shutoff,
    input wire logic o_aout_enable,
    input wire logic [iclr_pkg::DATA_W-1:0] o_aout_min,
    input wire logic [iclr_pkg::DATA_W-1:0] o_aout_max,
    input wire iclr_pkg::iclr_temp_mode_t o_temp_mode,
    input wire logic signed [iclr_pkg::DATA_W-1:0] o_temp_setpoint,
    input wire logic o_temp_demand
);
    import iclr_pkg::*;
    default clocking dc @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // pump and heartbeat follow their register writes
    AST_RUN_INV: assert property (
        i_wr && i_addr == ADDR_PUMP_INHIBIT
        |=> o_pump_run_cmd == !$past(i_wdata[0]))
        else $error("run command not inverse of inhibit");
    AST_HB_ON: assert property (
        i_wr && i_addr == ADDR_HEARTBEAT_TICK && o_comms_watch_on
        |=> o_heartbeat_tick
        && o_heartbeat_count == $past(o_heartbeat_count) + 16'h0001)
        else $error("heartbeat write not counted");
    AST_HB_OFF: assert property (
        i_wr && i_addr == ADDR_HEARTBEAT_TICK && !o_comms_watch_on
        |=> !o_heartbeat_tick && $stable(o_heartbeat_count))
        else $error("heartbeat counted while watch off");
    // gated outputs stay quiet while their enable is off
    AST_TANK_GATE: assert property (
        !i_tank_level_monitor_option [*4]
        |-> !o_tank_notify && !o_tank_shutoff)
        else $error("tank trigger without monitor option");
    AST_AOUT_GATE: assert property (
        !o_aout_enable |=> o_aout_min == 0 && o_aout_max == 0)
        else $error("analog limits while output disabled");
    AST_MODE_GATE: assert property (
        o_temp_mode == TM_DISABLED || o_temp_mode == TM_DISPLAY
        |=> !o_temp_demand)
        else $error("temperature demand in passive mode");
    AST_ABOVE: assert property (
        o_temp_mode == TM_ON_ABOVE |=> o_temp_demand
        == ($past(i_temperature) > $past(o_temp_setpoint)))
        else $error("on-above demand wrong");
    // setpoint range, read-only copies and read answers
    AST_SETPT_RANGE: assert property (
        o_temp_setpoint >= TEMP_MIN && o_temp_setpoint <= TEMP_MAX)
        else $error("setpoint outside range");
    AST_RO_TEMP: assert property (
        i_wr && (i_addr == ADDR_TEMP_SETPOINT_VIEW + 20'h0_0001
        || i_addr == ADDR_TEMP_MODE_VIEW + 20'h0_0001)
        |=> $stable(o_temp_setpoint) && $stable(o_temp_mode))
        else $error("read-only copy write took effect");
    AST_RD_ANS: assert property (
        i_rd |=> o_rd_valid && (!o_rd_err || o_rdata == 16'h0000))
        else $error("read answer missing or bad");
endmodule

bind iclr_regs iclr_regs_props u_props (.*);

// ### sim/tb.sv
// self-checking bench of the injection controller register bank
`timescale 1ns/10ps
module tb;
    import iclr_pkg::*;
    logic i_ref_clk, i_rst, i_wr, i_rd, o_rd_valid, o_rd_err;
    logic [ADDR_W-1:0] i_addr;
    logic [WORD_W-1:0] i_wdata, o_rdata, o_flow_rate_target;
    logic [WORD_W-1:0] o_heartbeat_count, i_tank_height;
    logic o_pump_run_cmd, i_flow_mode, i_volume_tick, o_alarm_clear;
    logic o_heartbeat_tick, o_comms_watch_on, o_tank_notify;
    logic i_tank_level_monitor_option, o_tank_shutoff, o_aout_enable;
    logic [DATA_W-1:0] i_aout_kind, o_aout_min, o_aout_max, r;
    logic signed [DATA_W-1:0] i_temperature, o_temp_setpoint;
    iclr_pump_code_t i_lockout_code;
    iclr_temp_mode_t o_temp_mode;
    logic o_temp_demand;
    logic [16:0] exp_q[$];
    int fail_count, samples_checked, cyc;
    logic [15:0] tk_in[5] = '{16'h3840, 16'h3841, 16'h8000, 16'h0, 16'h7fff};
    logic [15:0] tk_out[5] = '{16'h3840, 16'h3840, 16'h0, 16'h0, 16'h3840};
    logic [31:0] sp_in[4] = '{32'hffff_ffd8, 32'hffff_ffd7, 32'h0000_0076,
        32'h0000_0077};
    logic [31:0] sp_out[4] = '{32'hffff_ffd8, 32'hffff_ffd8, 32'h0000_0076,
        32'h0000_0076};

    iclr_mbus_master u_mst (.i_ref_clk(i_ref_clk), .o_wr(i_wr),
        .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
    iclr_regs u_dut (.*);

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr16(input logic [19:0] a, input logic [15:0] d);
        u_mst.access(1'b1, a, d);
    endtask
    task automatic wr32(input logic [19:0] a, input logic [31:0] d);
        wr16(a, d[31:16]);
        wr16(a + 20'h0_0001, d[15:0]);
    endtask
    task automatic rd16(input logic [19:0] a, input logic [16:0] want);
        exp_q.push_back(want);
        u_mst.access(1'b0, a, 16'h0000);
    endtask
    task automatic rd32(input logic [19:0] a, input logic [31:0] want);
        rd16(a, {1'b0, want[31:16]});
        rd16(a + 20'h0_0001, {1'b0, want[15:0]});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    // clock and hang guard
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            summarize();
        end
    end
    // each answered read takes the oldest note
    always @(negedge i_ref_clk) begin
        if (o_rd_valid === 1'b1) begin
            chk({15'h0, o_rd_err, o_rdata},
                {15'h0, exp_q.pop_front()});
        end
    end

    initial begin
        void'($urandom(7034));
        i_rst = 1'b1;
        i_lockout_code = PS_STANDBY;
        i_flow_mode = 1'b0;
        i_volume_tick = 1'b0;
        i_tank_level_monitor_option = 1'b0;
        i_tank_height = 16'h0064;
        i_aout_kind = $urandom;
        i_temperature = 32'($urandom_range(157)) - 32'sh0000_0028;
        idle(16);
        i_rst = 1'b0;
        idle(1);
        // pump status, inhibit and lockout codes
        rd16(ADDR_PUMP_STATE_LOW, 17'h0_0000);
        rd16(ADDR_PUMP_INHIBIT, 17'h0_0001);
        wr16(ADDR_PUMP_INHIBIT, 16'h0000);
        chk(32'(o_pump_run_cmd), 32'h0000_0001);
        rd16(ADDR_PUMP_STATE_LOW, 17'h0_0001);
        for (int c = 2; c < 6; c++) begin
            i_lockout_code = iclr_pump_code_t'(c);
            rd16(ADDR_PUMP_STATE_LOW, 17'(c));
        end
        i_lockout_code = PS_STANDBY;
        wr16(ADDR_PUMP_STATE_LOW, 16'h0001);
        wr16(ADDR_PUMP_INHIBIT, 16'h0001);
        rd16(ADDR_PUMP_STATE_LOW, 17'h0_0000);
        wr16(ADDR_ALARM_CLEAR, 16'h0001);
        chk(32'(o_alarm_clear), 32'h0000_0001);
        rd16(ADDR_ALARM_CLEAR, 17'h0_0000);
        rd16(ADDR_LAST + 20'h0_0001, 17'h1_0000);
        // totaliser wraps and counts in flow mode only
        wr16(ADDR_DESIRED_FLOW_RATE, 16'h1770);
        chk(32'(o_flow_rate_target), 32'h0000_1770);
        i_flow_mode = 1'b1;
        wr16(ADDR_GRAND_TOTAL_SHORT, 16'h7ffe);
        for (int k = 0; k < 3; k++) begin
            i_flow_mode = (k < 2);
            i_volume_tick = 1'b1;
            idle(1);
            i_volume_tick = 1'b0;
            rd16(ADDR_GRAND_TOTAL_SHORT,
                (k == 0) ? 17'h0_7fff : 17'h0_0000);
        end
        // heartbeat counts only while the watch is on
        wr16(ADDR_HEARTBEAT_TICK, 16'($urandom));
        chk(32'(o_heartbeat_count), 32'h0000_0000);
        wr16(ADDR_COMMS_WATCH_ENABLE, 16'h0001);
        chk(32'(o_comms_watch_on), 32'h0000_0001);
        wr16(ADDR_HEARTBEAT_TICK, 16'($urandom));
        wr16(ADDR_HEARTBEAT_TICK, 16'h0000);
        idle(1);
        chk(32'(o_heartbeat_count), 32'h0000_0002);
        // tank triggers clamp; outputs need the option
        foreach (tk_in[i]) begin
            wr16(ADDR_TANK_NOTIFY_LEVEL, tk_in[i]);
            rd16(ADDR_TANK_NOTIFY_LEVEL, {1'b0, tk_out[i]});
        end
        wr16(ADDR_TANK_SHUTOFF_LEVEL, 16'hffff);
        rd16(ADDR_TANK_SHUTOFF_LEVEL, 17'h0_0000);
        chk(32'(o_tank_notify), 32'h0000_0000);
        i_tank_level_monitor_option = 1'b1;
        idle(4);
        chk(32'({o_tank_notify, o_tank_shutoff}), 32'h0000_0002);
        // analog limits reach the outputs only while enabled
        r = $urandom;
        wr32(ADDR_ANALOG_OUT_MIN, r);
        wr32(ADDR_ANALOG_OUT_MAX, ~r);
        idle(1);
        chk(o_aout_min | o_aout_max, 32'h0000_0000);
        rd32(ADDR_ANALOG_OUT_MIN_VIEW, r);
        rd32(ADDR_ANALOG_OUT_KIND, i_aout_kind);
        wr32(ADDR_ANALOG_OUT_MAX_VIEW, 32'h0000_0000);
        wr32(ADDR_ANALOG_OUT_ON, 32'h0000_0001);
        chk(32'(o_aout_enable), 32'h0000_0001);
        idle(1);
        chk(o_aout_min, r);
        chk(o_aout_max, ~r);
        rd32(ADDR_ANALOG_OUT_ON_VIEW, 32'h0000_0001);
        // setpoint filter, every mode code, read-only copies
        foreach (sp_in[i]) begin
            wr32(ADDR_TEMP_SETPOINT, sp_in[i]);
            chk(o_temp_setpoint, sp_out[i]);
        end
        for (int m = 0; m < 4; m++) begin
            wr32(ADDR_TEMP_MODE, 32'(m));
            idle(1);
            chk(32'({o_temp_mode, o_temp_demand}),
                32'(m * 2 + (m == 2)));
        end
        wr32(ADDR_TEMP_MODE, 32'h0000_0005);
        wr32(ADDR_TEMP_MODE_VIEW, 32'h0000_0001);
        wr32(ADDR_TEMP_SETPOINT_VIEW, 32'h0000_0000);
        rd32(ADDR_TEMP_MODE_VIEW, 32'h0000_0003);
        rd32(ADDR_TEMP_SETPOINT_VIEW, 32'h0000_0076);
        rd32(ADDR_TEMPERATURE_READING, i_temperature);
        idle(3);
        chk(32'(exp_q.size()), 32'h0000_0000);
        summarize();
    end
endmodule
